// ==== common/ipt_consts.svh ====
`ifndef IPT_CONSTS_SVH
`define IPT_CONSTS_SVH
`define IPT_CTRL_OFS   8'h00
`define IPT_WBITS_OFS  8'h04
`define IPT_SLEN_OFS   8'h08
`define IPT_STAT_OFS   8'h0C
`define IPT_MASK_OFS   8'h10
`define IPT_MSTATE_OFS 8'h14
`define IPT_ENT_BASE   8'h80
`define IPT_CTRL_EN    0
`define IPT_CTRL_PRE   1
`define IPT_CTRL_RSTRT 2
`define IPT_ST_TRIG    0
`define IPT_ST_WORD    1
`define IPT_ST_BRK     2
`define IPT_ENT_CHAN   0
`define IPT_ENT_CONT   1
`define IPT_CTRL_INIT  2'h0
`define IPT_WBITS_INIT 5'h10
`define IPT_SLEN_INIT  5'h01
`define IPT_MAX_BITS   24
`define IPT_MAX_ENT    16
`define IPT_RESP_OK    2'h0
`define IPT_RESP_ERR   2'h2
`endif

// ==== common/ipt_pkg.sv ====
`include "ipt_consts.svh"
package ipt_pkg;
   typedef struct packed {
      logic sck;
      logic ws;
      logic sd;
   } ipt_pins_s;
   typedef struct packed {
      logic                       chan;
      logic [`IPT_MAX_BITS-1:0]   data;
   } ipt_word_s;
   typedef struct packed {
      logic                       contig;
      logic                       chan;
      logic [`IPT_MAX_BITS-1:0]   value;
   } ipt_entry_s;
   typedef enum logic {DS_SEEK, DS_SHIFT} ipt_deser_e;
   typedef enum logic [1:0] {MS_OFF, MS_HUNT, MS_DONE} ipt_match_e;
endpackage : ipt_pkg

// ==== rtl/ipt_sync.sv ====
`timescale 1ns/1ps
module ipt_sync #(
   parameter int W = 3
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : ipt_sync

// ==== rtl/ipt_deser.sv ====
`timescale 1ns/1ps
`include "ipt_consts.svh"
module ipt_deser
   import ipt_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire ipt_pins_s  pins,
   input  wire logic [4:0] wordBits,
   output logic            wordValid,
   output ipt_word_s       word
);
   ipt_deser_e               st_r;
   logic                     sckLast_r;
   logic                     wsLast_r;
   logic [4:0]               cnt_r;
   logic [`IPT_MAX_BITS-1:0] sh_r;
   logic                     chan_r;

   wire sckRise = pins.sck & ~sckLast_r;
   wire wsFlip  = pins.ws ^ wsLast_r;
   wire lastBit = (5'(cnt_r + 5'h01) == wordBits);

   // Bit at the select edge is dropped; the new word starts with the next bit
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= DS_SEEK;
         sckLast_r <= 1'b0;
         wsLast_r  <= 1'b0;
         cnt_r     <= 5'h00;
         sh_r      <= '0;
         chan_r    <= 1'b0;
         wordValid <= 1'b0;
      end else begin
         sckLast_r <= pins.sck;
         wordValid <= 1'b0;
         if (sckRise) begin
            wsLast_r <= pins.ws;
            if (wsFlip) begin // R1
               st_r   <= DS_SHIFT;
               cnt_r  <= 5'h00;
               sh_r   <= '0;
               chan_r <= pins.ws; // R3
            end else if (st_r == DS_SHIFT) begin
               sh_r  <= {sh_r[`IPT_MAX_BITS-2:0], pins.sd};
               cnt_r <= 5'(cnt_r + 5'h01); // R2
               if (lastBit) begin
                  st_r      <= DS_SEEK;
                  wordValid <= 1'b1;
               end
            end
         end
      end
   end
   assign word = '{chan: chan_r, data: sh_r};

   AST_WORD_START: assert property ( // R1
      @(posedge clock) disable iff (!rst_n)
      sckRise && wsFlip |=> st_r == DS_SHIFT && cnt_r == 5'h00 && chan_r == $past(pins.ws))
      else $error("Word start not taken at select edge");
   AST_WORD_BITS: assert property ( // R2
      @(posedge clock) disable iff (!rst_n)
      wordValid |-> cnt_r == $past(wordBits) && st_r == DS_SEEK)
      else $error("Word length differs from programmed width");
endmodule : ipt_deser

// ==== rtl/ipt_trigger.sv ====
// Operation
// R1: Three probed pins: clock, select, data
// R2: Word width programmable from 1 to 24
// R3: Entry matches only its channel and value
// R4: Contiguous entry must match the next word
// R5: Non-contiguous entry waits across unmatched words
// R6: Sequence holds at most sixteen entries
// R7: Pre-fill holds trigger until memory filled
// R8: One trigger pulse; contiguous break restarts sequence
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ipt_consts.svh"
module ipt_trigger
   import ipt_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              sckPin,
   input  wire logic              wsPin,
   input  wire logic              sdPin,
   input  wire logic              fillReached,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   trigger,
   output logic                   irq
);
   ipt_pins_s  pinsSync;
   logic       wordValid;
   ipt_word_s  word;

   logic [1:0]  ctrl_r;
   logic [4:0]  wordBits_r;
   logic [4:0]  seqLen_r;
   logic [2:0]  status_r;
   logic [2:0]  mask_r;
   ipt_entry_s  entry_r [`IPT_MAX_ENT];
   ipt_match_e  mState_r;
   logic [3:0]  idx_r;
   logic        awHave_r;
   logic        wHave_r;
   logic [7:0]  wAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;

   ipt_sync #(.W(3)) uSync ( // R1
      .clock (clock),
      .rst_n (rst_n),
      .d     ({sckPin, wsPin, sdPin}),
      .q     (pinsSync)
   );

   ipt_deser uDeser (
      .clock     (clock),
      .rst_n     (rst_n),
      .pins      (pinsSync),
      .wordBits  (wordBits_r),
      .wordValid (wordValid),
      .word      (word)
   );

   // Write decode
   wire        doWrite = awHave_r & wHave_r & ~bvalid;
   wire [31:0] bMask   = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
   wire [31:0] wMasked = wData_r & bMask;
   wire [7:0]  wW      = {wAddr_r[7:2], 2'b00};
   wire        wEnt    = wAddr_r[7];
   wire [3:0]  wIdx    = wAddr_r[6:3];
   wire        wCtrl   = doWrite & ~wEnt & (wW == `IPT_CTRL_OFS) & wStrb_r[0];
   wire        wWbits  = doWrite & ~wEnt & (wW == `IPT_WBITS_OFS) & wStrb_r[0];
   wire        wSlen   = doWrite & ~wEnt & (wW == `IPT_SLEN_OFS) & wStrb_r[0];
   wire        wStat   = doWrite & ~wEnt & (wW == `IPT_STAT_OFS) & wStrb_r[0];
   wire        wMask   = doWrite & ~wEnt & (wW == `IPT_MASK_OFS) & wStrb_r[0];
   wire        wEntVal = doWrite & wEnt & ~wAddr_r[2];
   wire        wEntFlg = doWrite & wEnt & wAddr_r[2] & wStrb_r[0];
   wire        wMapped = wEnt | (wW <= `IPT_MSTATE_OFS);
   wire        restart = wCtrl & wData_r[`IPT_CTRL_RSTRT];
   wire [`IPT_MAX_BITS-1:0] entValNxt = (entry_r[wIdx].value & ~bMask[`IPT_MAX_BITS-1:0])
                                      | wMasked[`IPT_MAX_BITS-1:0];
   // Out-of-range settings clamp so the matcher never sees an illegal width
   wire [4:0]  wbitsNxt = (wData_r[4:0] == 5'h00) ? 5'h01 :
                          (wData_r[4:0] > 5'(`IPT_MAX_BITS)) ? 5'(`IPT_MAX_BITS) : wData_r[4:0];
   wire [4:0]  slenNxt  = (wData_r[4:0] == 5'h00) ? 5'h01 :
                          (wData_r[4:0] > 5'(`IPT_MAX_ENT)) ? 5'(`IPT_MAX_ENT) : wData_r[4:0];

   // Read decode
   wire [7:0]  rA    = araddr[7:0];
   wire [7:0]  rW    = {rA[7:2], 2'b00};
   ipt_entry_s rEnt;
   assign rEnt = entry_r[rA[6:3]];
   wire        rMapped = rA[7] | (rW <= `IPT_MSTATE_OFS);
   wire [31:0] rEntData = rA[2] ? {30'h0, rEnt.contig, rEnt.chan}
                                : {8'h00, rEnt.value};
   wire [31:0] rRegData =
      (rW == `IPT_CTRL_OFS)   ? {30'h0, ctrl_r} :
      (rW == `IPT_WBITS_OFS)  ? {27'h0, wordBits_r} :
      (rW == `IPT_SLEN_OFS)   ? {27'h0, seqLen_r} :
      (rW == `IPT_STAT_OFS)   ? {29'h0, status_r} :
      (rW == `IPT_MASK_OFS)   ? {29'h0, mask_r} :
      (rW == `IPT_MSTATE_OFS) ? {26'h0, mState_r, idx_r} : 32'h0;
   wire [31:0] rDataNxt = ~rMapped ? 32'h0 : (rA[7] ? rEntData : rRegData);

   // Matcher
   ipt_entry_s cur;
   ipt_entry_s first;
   assign cur   = entry_r[idx_r];
   assign first = entry_r[0];
   wire [`IPT_MAX_BITS-1:0] wMaskBits = `IPT_MAX_BITS'((25'h1 << wordBits_r) - 25'h1);
   wire [3:0]  lastIdx  = 4'(seqLen_r - 5'h01); // R6
   wire        gate     = ctrl_r[`IPT_CTRL_EN]
                        & (~ctrl_r[`IPT_CTRL_PRE] | fillReached); // R7
   wire        wordOk   = wordValid & gate & (mState_r == MS_HUNT);
   wire        hitCur   = (word.chan == cur.chan)
                        & ((word.data & wMaskBits) == (cur.value & wMaskBits)); // R3
   wire        hitFirst = (word.chan == first.chan)
                        & ((word.data & wMaskBits) == (first.value & wMaskBits));
   // Restart in the same cycle discards the final match
   wire        fire     = wordOk & hitCur & (idx_r == lastIdx) & ~restart; // R8
   wire        brk      = wordOk & ~hitCur & (idx_r != 4'h0) & cur.contig; // R4 R5
   logic [2:0] statSet;
   assign statSet[`IPT_ST_TRIG] = fire;
   assign statSet[`IPT_ST_WORD] = wordValid;
   assign statSet[`IPT_ST_BRK]  = brk;
   wire [2:0]  statClr = wStat ? wData_r[2:0] : 3'h0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mState_r <= MS_OFF;
         idx_r    <= 4'h0;
      end else if (!ctrl_r[`IPT_CTRL_EN]) begin
         mState_r <= MS_OFF;
         idx_r    <= 4'h0;
      end else if (restart) begin
         mState_r <= MS_HUNT;
         idx_r    <= 4'h0;
      end else begin
         unique case (mState_r)
            MS_OFF:  mState_r <= MS_HUNT;
            MS_HUNT: begin
               if (fire) begin
                  mState_r <= MS_DONE; // R8
                  idx_r    <= 4'h0;
               end else if (wordOk & hitCur) begin
                  idx_r <= 4'(idx_r + 4'h1);
               end else if (brk) begin
                  idx_r <= hitFirst ? 4'h1 : 4'h0; // R8
               end
            end
            MS_DONE: mState_r <= MS_DONE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r     <= `IPT_CTRL_INIT;
         wordBits_r <= `IPT_WBITS_INIT;
         seqLen_r   <= `IPT_SLEN_INIT;
         mask_r     <= 3'h0;
         for (int i = 0; i < `IPT_MAX_ENT; i++) begin
            entry_r[i] <= '0;
         end
      end else begin
         if (wCtrl) ctrl_r <= wData_r[1:0];
         if (wWbits) wordBits_r <= wbitsNxt; // R2
         if (wSlen) seqLen_r <= slenNxt; // R6
         if (wMask) mask_r <= wData_r[2:0];
         if (wEntVal) entry_r[wIdx].value <= entValNxt;
         if (wEntFlg) begin
            entry_r[wIdx].chan   <= wData_r[`IPT_ENT_CHAN];
            entry_r[wIdx].contig <= wData_r[`IPT_ENT_CONT];
         end
      end
   end

   // Hardware set wins over a same-cycle software clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= 3'h0;
         trigger  <= 1'b0;
         irq      <= 1'b0;
      end else begin
         status_r <= (status_r & ~statClr) | statSet;
         trigger  <= fire; // R8
         irq      <= |(status_r & mask_r);
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         awready  <= 1'b1;
         wready   <= 1'b1;
         awHave_r <= 1'b0;
         wHave_r  <= 1'b0;
         wAddr_r  <= 8'h00;
         wData_r  <= 32'h0;
         wStrb_r  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= `IPT_RESP_OK;
      end else begin
         if (awvalid & awready) begin
            awready  <= 1'b0;
            awHave_r <= 1'b1;
            wAddr_r  <= awaddr[7:0];
         end
         if (wvalid & wready) begin
            wready  <= 1'b0;
            wHave_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (doWrite) begin
            awHave_r <= 1'b0;
            wHave_r  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= wMapped ? `IPT_RESP_OK : `IPT_RESP_ERR;
         end
         if (bvalid & bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `IPT_RESP_OK;
      end else if (arvalid & arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rDataNxt;
         rresp   <= rMapped ? `IPT_RESP_OK : `IPT_RESP_ERR;
      end else if (rvalid & rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   AST_TRIG_CAUSE: assert property ( // R8
      @(posedge clock) disable iff (!rst_n)
      trigger |-> $past(wordValid) && $past(idx_r) == $past(lastIdx) && mState_r == MS_DONE)
      else $error("Trigger without final entry match");
   AST_TRIG_ONCE: assert property ( // R8
      @(posedge clock) disable iff (!rst_n)
      trigger && !restart |=> !trigger)
      else $error("Trigger fired twice for one sequence");
   AST_PREFILL: assert property ( // R7
      @(posedge clock) disable iff (!rst_n)
      ctrl_r[`IPT_CTRL_PRE] && !fillReached |=> !trigger
      && idx_r == (($past(restart) || !$past(ctrl_r[`IPT_CTRL_EN])) ? 4'h0 : $past(idx_r)))
      else $error("Match honoured before capture memory filled");
   AST_CONTIG: assert property ( // R4
      @(posedge clock) disable iff (!rst_n)
      brk && !restart && ctrl_r[`IPT_CTRL_EN] |=> idx_r == ($past(hitFirst) ? 4'h1 : 4'h0))
      else $error("Contiguous break did not restart sequence");
   AST_NONCONT: assert property ( // R5
      @(posedge clock) disable iff (!rst_n)
      wordOk && !hitCur && !cur.contig && !restart |=> idx_r == $past(idx_r))
      else $error("Non-contiguous entry lost its place");
   AST_CHAN: assert property ( // R3
      @(posedge clock) disable iff (!rst_n)
      wordOk && word.chan != cur.chan |=> !trigger && idx_r <= $past(idx_r))
      else $error("Word of wrong channel advanced the sequence");
   AST_SEQLEN: assert property ( // R6
      @(posedge clock) disable iff (!rst_n)
      seqLen_r >= 5'h01 && seqLen_r <= 5'(`IPT_MAX_ENT) && wordBits_r >= 5'h01)
      else $error("Sequence length out of range");
   AST_IRQ: assert property (
      @(posedge clock) disable iff (!rst_n)
      trigger && mask_r[`IPT_ST_TRIG] && !wStat |=> irq)
      else $error("Trigger did not raise interrupt");
endmodule : ipt_trigger

// ==== verif/ipt_i2s_src.sv ====
`timescale 1ns/1ps
module ipt_i2s_src (
   output logic sck,
   output logic ws,
   output logic sd
);
   initial begin
      sck = 1'h0;
      ws  = 1'h0;
      sd  = 1'h0;
   end

   // Clock stands still between words; idle data flips so no stale bit looks valid
   task automatic send(input logic ch, input logic [23:0] v, input int n);
      ws = ch;
      sd = ~sd;
      #62.5 sck = 1'h1;
      #62.5 sck = 1'h0;
      for (int i = n - 1; i >= 0; i--) begin
         sd = v[i];
         #62.5 sck = 1'h1;
         #62.5 sck = 1'h0;
      end
      sd = ~sd;
   endtask : send
endmodule : ipt_i2s_src

// ==== verif/ipt_trigger_tb.sv ====
`timescale 1ns/1ps
`include "ipt_consts.svh"
module ipt_trigger_tb;
   logic        clock = 1'h0;
   logic        rst_n = 1'h0;
   logic        fillReached = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        sck, ws, sd, awready, wready, bvalid, arready, rvalid, trigger, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [33:0] expQ[$];
   logic [33:0] rv[7] = '{34'h0, {29'h0, `IPT_WBITS_INIT}, {29'h0, `IPT_SLEN_INIT},
                          34'h0, 34'h0, 34'h0, 34'h200000000};
   logic [23:0] v[16];
   int          err_total = 0, total_checks = 0, trigSeen = 0, cycles = 0, w = 24;

   always #2.5 clock = ~clock;

   ipt_trigger i_ipt_trigger (
      .clock, .rst_n, .sckPin(sck), .wsPin(ws), .sdPin(sd), .fillReached,
      .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
      .rresp, .trigger, .irq
   );
   ipt_i2s_src i_ipt_i2s_src (.sck, .ws, .sd);

   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   // Starts one edge late so no signal is assigned twice in one time step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clock);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do begin
         @(posedge clock);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      check("bresp", bresp, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge clock);
      expQ.push_back(e);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do begin
         @(posedge clock);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
   endtask : rd

   task automatic ent(input int i, input logic ch, input logic ct, input logic [23:0] d);
      wr(`IPT_ENT_BASE + 8'(8 * i), {8'h00, d}, 2'h0);
      wr(`IPT_ENT_BASE + 8'(8 * i + 4), {30'h0, ct, ch}, 2'h0);
   endtask : ent

   task automatic snd(input logic c, input logic [23:0] d);
      i_ipt_i2s_src.send(c, d, w);
   endtask : snd

   always @(posedge clock) begin
      cycles++;
      if (trigger === 1'h1) trigSeen++;
      if (rvalid === 1'h1 && rready === 1'h1 && expQ.size() > 0) begin
         check("rdata", {rresp, rdata}, expQ.pop_front());
      end
      if (cycles == 80000) begin
         err_total++;
         conclude();
      end
   end

   initial begin
      void'($urandom(23890));
      repeat (3) @(posedge clock);
      rst_n <= 1'h1;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), rv[i]);
      wr(8'h7C, 32'h1, 2'h2);
      wr(`IPT_WBITS_OFS, 32'h0, 2'h0);
      rd(`IPT_WBITS_OFS, 34'h1);
      wr(`IPT_WBITS_OFS, 32'h19, 2'h0);
      rd(`IPT_WBITS_OFS, 34'h18);
      wr(`IPT_SLEN_OFS, 32'h11, 2'h0);
      rd(`IPT_SLEN_OFS, 34'h10);
      // Full-width contiguous pair; wrong channel first, then a break
      ent(0, 1'h0, 1'h0, 24'hABCDEF);
      ent(1, 1'h1, 1'h1, 24'h123456);
      wr(`IPT_SLEN_OFS, 32'h2, 2'h0);
      wr(`IPT_MASK_OFS, 32'h7, 2'h0);
      wr(`IPT_CTRL_OFS, 32'h1, 2'h0);
      snd(1'h1, 24'hABCDEF);
      snd(1'h0, 24'hABCDEF);
      snd(1'h1, 24'h000001);
      snd(1'h0, 24'h000002);
      snd(1'h1, 24'h123456);
      check("trigger", trigSeen, 0);
      snd(1'h0, 24'hABCDEF);
      snd(1'h1, 24'h123456);
      check("trigger", trigSeen, 1);
      snd(1'h0, 24'hABCDEF);
      snd(1'h1, 24'h123456);
      check("trigger", trigSeen, 1);
      rd(`IPT_STAT_OFS, 34'h7);
      rd(`IPT_MSTATE_OFS, 34'h20);
      check("irq", irq, 1'h1);
      wr(`IPT_MASK_OFS, 32'h0, 2'h0);
      repeat (2) @(posedge clock);
      check("irq", irq, 1'h0);
      wr(`IPT_MASK_OFS, 32'h1, 2'h0);
      repeat (2) @(posedge clock);
      check("irq", irq, 1'h1);
      wr(`IPT_STAT_OFS, 32'h7, 2'h0);
      repeat (2) @(posedge clock);
      check("irq", irq, 1'h0);
      // Random width, gaps between entries
      w = $urandom_range(24, 1);
      for (int i = 0; i < 16; i++) v[i] = 24'($urandom);
      wr(`IPT_WBITS_OFS, 32'(w), 2'h0);
      wr(`IPT_SLEN_OFS, 32'h3, 2'h0);
      ent(0, 1'h0, 1'h0, v[0]);
      ent(1, 1'h1, 1'h0, v[1]);
      ent(2, 1'h0, 1'h0, v[2]);
      wr(`IPT_CTRL_OFS, 32'h5, 2'h0);
      snd(1'h0, v[0]);
      snd(1'h1, v[1] ^ 24'h1);
      snd(1'h0, v[2] ^ 24'h1);
      snd(1'h1, v[1]);
      snd(1'h0, v[2]);
      check("trigger", trigSeen, 2);
      // Longest sequence, held off until memory is filled
      wr(`IPT_SLEN_OFS, 32'h10, 2'h0);
      for (int i = 0; i < 16; i++) ent(i, ~i[0], 1'h0, v[i]);
      wr(`IPT_CTRL_OFS, 32'h7, 2'h0);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 16; i++) snd(~i[0], v[i]);
         check("trigger", trigSeen, 2 + p);
         @(posedge clock);
         fillReached <= 1'h1;
      end
      conclude();
   end
endmodule : ipt_trigger_tb
